// file: exec_pkg.sv
package exec_pkg;
   localparam int NUM_REGS = 32;
   localparam int ADDR_W = 16;
   // Status flag bit positions
   localparam logic [2:0] FLAG_CARRY = 3'h0;
   localparam logic [2:0] FLAG_ZERO = 3'h1;
   localparam logic [2:0] FLAG_NEG = 3'h2;
   localparam logic [2:0] FLAG_OVF = 3'h3;
   localparam logic [2:0] FLAG_SIGN = 3'h4;
   localparam logic [2:0] FLAG_HALF = 3'h5;
   localparam logic [2:0] FLAG_XFER = 3'h6;
   localparam logic [2:0] FLAG_GIE = 3'h7;
   // Low register of each pointer pair
   localparam logic [4:0] PTR_X_LO = 5'h1A;
   localparam logic [4:0] PTR_Y_LO = 5'h1C;
   localparam logic [4:0] PTR_Z_LO = 5'h1E;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [7:0] REG_RESET = 8'h00;
   // AXI4-Lite byte offsets
   localparam logic [3:0] OFS_FLAGS = 4'h0;
   localparam logic [3:0] OFS_EXEC = 4'h4;
   localparam logic [3:0] OFS_GPR_SEL = 4'h8;
   localparam logic [3:0] OFS_GPR_DATA = 4'hC;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      OP_NOP = 3'h0,
      OP_FLAG_SET = 3'h1,
      OP_FLAG_CLEAR = 3'h2,
      OP_REGISTER_COPY = 3'h3,
      OP_REGISTER_PAIR_COPY = 3'h4,
      OP_IMMEDIATE_LOAD = 3'h5,
      OP_INDIRECT_LOAD = 3'h6
   } op_t;

   typedef enum logic [1:0] {
      LM_PLAIN = 2'h0,
      LM_POST_INC = 2'h1,
      LM_PRE_DEC = 2'h2,
      LM_DISPLACED = 2'h3
   } load_mode_t;

   typedef enum logic [1:0] {
      PTR_X = 2'h0,
      PTR_Y = 2'h1,
      PTR_Z = 2'h2
   } ptr_t;

   typedef enum logic [0:0] {
      ST_IDLE = 1'h0,
      ST_LOAD = 1'h1
   } state_t;

   typedef struct packed {
      op_t op;
      load_mode_t mode;
      ptr_t ptr;
      logic [4:0] rd;
      logic [4:0] rr;
      logic [7:0] imm;
   } instr_t;
endpackage : exec_pkg

// file: flag_and_load_exec.sv
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
module flag_and_load_exec
   import exec_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic instr_valid,
   input wire instr_t instr,
   output logic instr_ready,
   output logic retire,
   output logic mem_rd,
   output logic [ADDR_W-1:0] mem_addr,
   input wire logic [7:0] mem_rdata,
   output logic [7:0] status_flags,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   function automatic logic [4:0] ptr_base(input ptr_t p);
      case (p)
         PTR_X: ptr_base = PTR_X_LO;
         PTR_Y: ptr_base = PTR_Y_LO;
         default: ptr_base = PTR_Z_LO;
      endcase
   endfunction : ptr_base

   function automatic logic addr_mapped(input logic [3:0] a);
      addr_mapped = (a == OFS_FLAGS) || (a == OFS_EXEC) ||
         (a == OFS_GPR_SEL) || (a == OFS_GPR_DATA);
   endfunction : addr_mapped

   logic [7:0] regs_q [NUM_REGS];
   logic [7:0] regs_d [NUM_REGS];
   logic [7:0] flags_q, flags_d;
   state_t state_q, state_d;
   instr_t cur_q, cur_d;
   logic ready_q, ready_d;
   logic retire_q, retire_d;
   logic mem_rd_q, mem_rd_d;
   logic [ADDR_W-1:0] mem_addr_q, mem_addr_d;
   logic [7:0] retired_q, retired_d;
   logic [4:0] sel_q, sel_d;

   logic aw_got_q, aw_got_d, w_got_q, w_got_d;
   logic [3:0] awaddr_q, awaddr_d;
   logic [31:0] wdata_q, wdata_d;
   logic [3:0] wstrb_q, wstrb_d;
   logic bvalid_q, bvalid_d;
   logic [1:0] bresp_q, bresp_d;
   logic rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] rresp_q, rresp_d;
   logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
   logic wr_fire;

   // Bus write lands once both halves are held and no response is pending
   assign wr_fire = aw_got_q && w_got_q && !bvalid_q;

   always_comb begin
      aw_got_d = aw_got_q;
      w_got_d = w_got_q;
      awaddr_d = awaddr_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (s_axi_awvalid && !aw_got_q) begin
         aw_got_d = 1'b1;
         awaddr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_got_q) begin
         w_got_d = 1'b1;
         wdata_d = s_axi_wdata;
         wstrb_d = s_axi_wstrb;
      end
      if (wr_fire) begin
         bvalid_d = 1'b1;
         bresp_d = addr_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
         aw_got_d = 1'b0;
         w_got_d = 1'b0;
      end
      if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
      if (s_axi_arvalid && !rvalid_q) begin
         rvalid_d = 1'b1;
         rresp_d = addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         case (s_axi_araddr)
            OFS_FLAGS: rdata_d = {24'h000000, flags_q};
            OFS_EXEC: rdata_d = {16'h0000, retired_q, 7'h00, !ready_q};
            OFS_GPR_SEL: rdata_d = {27'h0000000, sel_q};
            OFS_GPR_DATA: rdata_d = {24'h000000, regs_q[sel_q]};
            default: rdata_d = 32'h00000000;
         endcase
      end
      awready_d = !aw_got_d;
      wready_d = !w_got_d;
      arready_d = !rvalid_d;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         awaddr_q <= 4'h0;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= RESP_OKAY;
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         arready_q <= 1'b1;
      end else begin
         aw_got_q <= aw_got_d;
         w_got_q <= w_got_d;
         awaddr_q <= awaddr_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
         awready_q <= awready_d;
         wready_q <= wready_d;
         arready_q <= arready_d;
      end
   end

   always_comb begin
      logic [4:0] base, base_hi, dst_lo, dst_hi, src_lo, src_hi;
      logic [ADDR_W-1:0] ptr, disp;
      base = ptr_base(state_q == ST_LOAD ? cur_q.ptr : instr.ptr);
      base_hi = 5'(base + 5'h01);
      // Pair copies always use the even register of each pair
      dst_lo = {instr.rd[4:1], 1'b0};
      dst_hi = {instr.rd[4:1], 1'b1};
      src_lo = {instr.rr[4:1], 1'b0};
      src_hi = {instr.rr[4:1], 1'b1};
      disp = ADDR_W'(instr.imm[5:0]);
      ptr = {regs_q[base_hi], regs_q[base]};
      regs_d = regs_q;
      flags_d = flags_q;
      state_d = state_q;
      cur_d = cur_q;
      ready_d = ready_q;
      retire_d = 1'b0;
      mem_rd_d = mem_rd_q;
      mem_addr_d = mem_addr_q;
      retired_d = retired_q;
      sel_d = sel_q;
      // Bus writes come first so a same-cycle instruction result wins
      if (wr_fire && wstrb_q[0]) begin
         case (awaddr_q)
            OFS_FLAGS: flags_d = wdata_q[7:0];
            OFS_GPR_SEL: sel_d = wdata_q[4:0];
            OFS_GPR_DATA: regs_d[sel_q] = wdata_q[7:0];
            default: ;
         endcase
      end
      case (state_q)
         ST_IDLE: begin
            if (instr_valid && ready_q) begin
               retire_d = instr.op != OP_INDIRECT_LOAD;
               retired_d = retired_q + 8'(retire_d);
               case (instr.op)
                  OP_FLAG_SET: begin
                     flags_d[instr.imm[2:0]] = 1'b1;
                  end
                  OP_FLAG_CLEAR: begin
                     flags_d[instr.imm[2:0]] = 1'b0;
                  end
                  OP_REGISTER_COPY: begin
                     regs_d[instr.rd] = regs_q[instr.rr];
                  end
                  OP_REGISTER_PAIR_COPY: begin
                     regs_d[dst_lo] = regs_q[src_lo];
                     regs_d[dst_hi] = regs_q[src_hi];
                  end
                  OP_IMMEDIATE_LOAD: regs_d[instr.rd] = instr.imm;
                  OP_INDIRECT_LOAD: begin
                     cur_d = instr;
                     state_d = ST_LOAD;
                     ready_d = 1'b0;
                     mem_rd_d = 1'b1;
                     case (instr.mode)
                        LM_PRE_DEC: mem_addr_d = ptr - 16'h0001;
                        LM_DISPLACED: mem_addr_d = ptr + disp;
                        default: mem_addr_d = ptr;
                     endcase
                  end
                  default: ;
               endcase
            end
         end
         ST_LOAD: begin
            // Pointer first: a load into its own pointer byte keeps the data
            case (cur_q.mode)
               LM_POST_INC: begin
                  {regs_d[base_hi], regs_d[base]} = ptr + 16'h0001;
               end
               LM_PRE_DEC: begin
                  {regs_d[base_hi], regs_d[base]} = mem_addr_q;
               end
               default: ;
            endcase
            regs_d[cur_q.rd] = mem_rdata;
            mem_rd_d = 1'b0;
            ready_d = 1'b1;
            retire_d = 1'b1;
            retired_d = retired_q + 8'h01;
            state_d = ST_IDLE;
         end
         default: begin
            state_d = ST_IDLE;
            ready_d = 1'b1;
            mem_rd_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            regs_q[i] <= REG_RESET;
         end
         flags_q <= FLAGS_RESET;
         state_q <= ST_IDLE;
         cur_q <= '0;
         ready_q <= 1'b1;
         retire_q <= 1'b0;
         mem_rd_q <= 1'b0;
         mem_addr_q <= 16'h0000;
         retired_q <= 8'h00;
         sel_q <= 5'h00;
      end else begin
         regs_q <= regs_d;
         flags_q <= flags_d;
         state_q <= state_d;
         cur_q <= cur_d;
         ready_q <= ready_d;
         retire_q <= retire_d;
         mem_rd_q <= mem_rd_d;
         mem_addr_q <= mem_addr_d;
         retired_q <= retired_d;
         sel_q <= sel_d;
      end
   end

   assign instr_ready = ready_q;
   assign retire = retire_q;
   assign mem_rd = mem_rd_q;
   assign mem_addr = mem_addr_q;
   assign status_flags = flags_q;
   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
endmodule : flag_and_load_exec

// file: flag_and_load_exec_asserts.sv
module flag_and_load_exec_asserts
   import exec_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic instr_valid,
   input wire instr_t instr,
   input wire logic instr_ready,
   input wire logic retire,
   input wire logic mem_rd,
   input wire logic [7:0] status_flags,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic tk;
   logic ld;
   assign tk = instr_valid && instr_ready;
   assign ld = tk && instr.op == OP_INDIRECT_LOAD;
   load_cycles_a:
   assert property (ld |=> mem_rd && !instr_ready && !retire
      ##1 retire && !mem_rd && $stable(status_flags))
      else $error("load did not finish in two cycles");
   short_op_a:
   assert property (tk && !ld |=> retire && !mem_rd && instr_ready)
      else $error("one-cycle op did not retire next cycle");
   flag_set_a:
   assert property (tk && instr.op == OP_FLAG_SET |=> status_flags ==
      ($past(status_flags) | (8'h01 << $past(instr.imm[2:0]))))
      else $error("flag set touched wrong bits");
   flag_clear_a:
   assert property (tk && instr.op == OP_FLAG_CLEAR |=> status_flags ==
      ($past(status_flags) & ~(8'h01 << $past(instr.imm[2:0]))))
      else $error("flag clear touched wrong bits");
   move_flags_a:
   assert property (tk && instr.op inside {OP_REGISTER_COPY,
      OP_REGISTER_PAIR_COPY, OP_IMMEDIATE_LOAD} |=> $stable(status_flags))
      else $error("move changed flags");
   read_cause_a:
   assert property (mem_rd |-> !instr_ready && $past(ld))
      else $error("memory read without a load");
   ar_ready_a: assert property (s_axi_arready == !s_axi_rvalid)
      else $error("arready not inverse of rvalid");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("rvalid dropped early");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped early");
   load_c: cover property (ld ##2 ld);
   set_c: cover property (tk && instr.op == OP_FLAG_SET);
   pair_c: cover property (tk && instr.op == OP_REGISTER_PAIR_COPY);
endmodule : flag_and_load_exec_asserts
bind flag_and_load_exec flag_and_load_exec_asserts chk (
   .aclk(aclk),
   .aresetn(aresetn),
   .instr_valid(instr_valid),
   .instr(instr),
   .instr_ready(instr_ready),
   .retire(retire),
   .mem_rd(mem_rd),
   .status_flags(status_flags),
   .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready),
   .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready)
);

// file: flag_and_load_exec_tb.sv
module flag_and_load_exec_tb
   import exec_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 1'h0, aresetn = 1'h0, instr_valid = 1'h0;
   instr_t instr = '0;
   logic instr_ready, retire, mem_rd;
   logic [ADDR_W-1:0] mem_addr;
   logic [7:0] mem_rdata, status_flags, ef;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
   // Ready held high, the bench always accepts answers at once
   logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs, bs;
   logic [15:0] p;
   logic [4:0] lo;
   int n_fail = 0, n_tests = 0;
   flag_and_load_exec uut (
      .aclk(aclk),
      .aresetn(aresetn),
      .instr_valid(instr_valid),
      .instr(instr),
      .instr_ready(instr_ready),
      .retire(retire),
      .mem_rd(mem_rd),
      .mem_addr(mem_addr),
      .mem_rdata(mem_rdata),
      .status_flags(status_flags),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready)
   );
   always #2.5 aclk = ~aclk;
   function automatic logic [7:0] mv(input logic [15:0] a);
      return a[7:0] ^ {a[11:8], a[15:12]} ^ 8'h5A;
   endfunction : mv
   // Inverted data outside the strobe exposes a late or early sample
   assign mem_rdata = mem_rd ? mv(mem_addr) : ~mv(mem_addr);
   task automatic check(input string nm, input logic [31:0] s, e);
      n_tests++;
      if (s !== e) begin
         n_fail++;
         $display("MISMATCH %s exp %h seen %h", nm, e, s);
      end
   endtask : check
   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_sim
   task automatic tmo(input int n);
      if (n >= 99) begin
         n_fail++;
         end_sim();
      end
   endtask : tmo
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      int n;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      for (n = 0; n < 99; n++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid) break;
      end
      bs = s_axi_bresp;
      tmo(n);
   endtask : wr
   task automatic rd(input logic [3:0] a);
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      for (n = 0; n < 99; n++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid) break;
      end
      v = s_axi_rdata;
      rs = s_axi_rresp;
      tmo(n);
   endtask : rd
   task automatic ex(input instr_t i);
      int n;
      instr <= i;
      instr_valid <= 1'h1;
      for (n = 0; n < 99; n++) begin
         @(posedge aclk);
         if (instr_ready) break;
      end
      tmo(n);
   endtask : ex
   task automatic idle();
      instr_valid <= 1'h0;
      repeat (2) @(posedge aclk);
   endtask : idle
   task automatic gw(input logic [4:0] r, input logic [7:0] d);
      wr(OFS_GPR_SEL, {27'h0, r});
      wr(OFS_GPR_DATA, {24'h0, d});
   endtask : gw
   task automatic gr(input logic [4:0] r, input logic [7:0] e);
      wr(OFS_GPR_SEL, {27'h0, r});
      rd(OFS_GPR_DATA);
      check($sformatf("r%0d", r), v, {24'h0, e});
   endtask : gr
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      ef = FLAGS_RESET;
      for (int k = 0; k < 16; k++) begin
         ex('{k < 8 ? OP_FLAG_SET : OP_FLAG_CLEAR, LM_PLAIN, PTR_X, 5'h0,
            5'h0, 8'(k % 8)});
         idle();
         ef[k % 8] = (k < 8);
         check("flags", status_flags, ef);
      end
      $display("test flags done");
      wr(OFS_FLAGS, 32'hA5);
      gw(5'h01, 8'h3C);
      ex('{OP_IMMEDIATE_LOAD, LM_PLAIN, PTR_X, 5'h02, 5'h0, 8'h81});
      ex('{OP_REGISTER_COPY, LM_PLAIN, PTR_X, 5'h03, 5'h01, 8'h0});
      // Odd indices check that the pair copy ignores the low bit
      ex('{OP_REGISTER_PAIR_COPY, LM_PLAIN, PTR_X, 5'h05, 5'h03, 8'h0});
      ex('{OP_NOP, LM_PLAIN, PTR_X, 5'h0, 5'h0, 8'h0});
      idle();
      gr(5'h02, 8'h81);
      gr(5'h03, 8'h3C);
      gr(5'h04, 8'h81);
      gr(5'h05, 8'h3C);
      check("flags", status_flags, 8'hA5);
      $display("test moves done");
      for (int k = 0; k < 3; k++) begin
         p = 16'h12FF + 16'(k) * 16'h2101;
         lo = PTR_X_LO + 5'(2 * k);
         gw(lo, p[7:0]);
         gw(lo + 5'h1, p[15:8]);
         ex('{OP_INDIRECT_LOAD, LM_PLAIN, ptr_t'(k), 5'h10, 5'h0, 8'h0});
         ex('{OP_INDIRECT_LOAD, LM_POST_INC, ptr_t'(k), 5'h11, 5'h0, 8'h0});
         ex('{OP_INDIRECT_LOAD, LM_DISPLACED, ptr_t'(k), 5'h12, 5'h0, 8'h3F});
         ex('{OP_INDIRECT_LOAD, LM_PRE_DEC, ptr_t'(k), 5'h13, 5'h0, 8'h0});
         idle();
         gr(5'h10, mv(p));
         gr(5'h11, mv(p));
         gr(5'h12, mv(p + 16'h40));
         gr(5'h13, mv(p));
         gr(lo, p[7:0]);
         gr(lo + 5'h1, p[15:8]);
      end
      check("load flags", status_flags, 8'hA5);
      $display("test loads done");
      rd(4'h2);
      check("unmapped resp", rs, RESP_SLVERR);
      check("unmapped data", v, 32'h00000000);
      wr(4'h6, 32'h000000FF);
      check("unmapped bresp", bs, RESP_SLVERR);
      // A write with lane 0 masked is answered but changes nothing
      s_axi_wstrb <= 4'h0;
      wr(OFS_FLAGS, 32'h00000000);
      check("masked bresp", bs, RESP_OKAY);
      check("masked flags", status_flags, 8'hA5);
      s_axi_wstrb <= 4'hF;
      wr(OFS_FLAGS, 32'h0000003C);
      check("flags bresp", bs, RESP_OKAY);
      rd(OFS_FLAGS);
      check("flags read", v, 32'h0000003C);
      // 16 flag ops, 4 moves including the no-op, 12 loads
      rd(OFS_EXEC);
      check("retired", v, 32'h00002000);
      $display("test bus done");
      end_sim();
   end
endmodule : flag_and_load_exec_tb
